// *** hw/adc_pkt_pkg.sv ***
// How it works
// (RL1) Route field holds destination identifier, reset zero
// (RL2) Pin enable bit includes pin in sampling
// (RL3) Dropped flag read-only, cleared by general read
// (RL4) Width code zero sends upper eight bits
// (RL5) Samples always left aligned in their width
// (RL6) Code one: sixteen bits, high byte first
// (RL7) Code three: thirty-two bits, high byte first
// (RL8) Samples-per-packet field ends each packet
// (RL9) Zero count: packet ends on route or general register access
// (RL10) Calibration bit selects internal reference input
// (RL11) Software discards one sample after mode switch
// (RL12) Converter enable locks the pin register
// (RL13) Software disables converter before pin setup
// (RL14) First six pulses after enable send nothing
// (RL15) Software issues six pulses on each enable
// (RL16) Each later pulse sends the pin's sample
// (RL17) Reserved bits read zero, ignore writes
// (RL18) Busy output drops new sample, sets flag
package adc_pkt_pkg;
    localparam logic [7:0] ROUTE_OFF = 8'h1C;
    localparam logic [7:0] GEN_OFF   = 8'h20;
    localparam logic [7:0] ISTAT_OFF = 8'h24;
    localparam logic [7:0] ICLR_OFF  = 8'h28;
    localparam logic [7:0] IEN_OFF   = 8'h2C;

    localparam int PIN_EN_BIT = 0;
    localparam int ROUTE_LSB  = 8;
    localparam int GEN_EN_BIT = 0;
    localparam int CAL_BIT    = 1;
    localparam int SPP_LSB    = 8;
    localparam int WID_LSB    = 16;
    localparam int DROP_BIT   = 24;
    localparam int IRQ_DROP   = 0;
    localparam int IRQ_EOP    = 1;

    localparam logic [23:0] ROUTE_RST = 24'h000000;
    localparam logic [7:0]  SPP_RST   = 8'h01;
    localparam logic [1:0]  WID_RST   = 2'h1;
    localparam logic        DROP_RST  = 1'b1;

    localparam logic [1:0] WID_8  = 2'h0;
    localparam logic [1:0] WID_32 = 2'h3;
    localparam logic [2:0] CAL_PULSES = 3'h6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/adc_pkt_ctrl.sv ***
`timescale 1ns/1ps
module adc_pkt_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic        sample_pulse,
    input  wire logic [11:0] conv_data,
    output logic             cal_sel,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_end,
    output logic [23:0]      tx_dest,
    output logic             irq
);
    import adc_pkt_pkg::*;

    logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r, w_data_r;
    logic [7:0]  aw_addr_r;
    logic [3:0]  w_strb_r;
    logic [23:0] route_r;
    logic        pin_en_r, en_r, cal_r, drop_r;
    logic [7:0]  spp_r, pkt_cnt_r;
    logic [1:0]  wid_r, istat_r, ien_r;
    logic        irq_r, pkt_open_r, end_pend_r;
    logic [2:0]  cal_cnt_r, bytes_left_r;
    logic [31:0] sh_r;
    logic        tx_valid_r, tx_end_r;
    logic [7:0]  tx_data_r;

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign cal_sel = cal_r;      // [RL10]
    assign tx_valid = tx_valid_r;
    assign tx_data  = tx_data_r;
    assign tx_end   = tx_end_r;
    assign tx_dest  = route_r;   // [RL1]
    assign irq      = irq_r;

    // Bus decode
    wire        wr_fire  = !awready_r && !wready_r && !bvalid_r;
    wire        ar_fire  = arvalid && arready_r;
    wire [7:0]  wa       = {aw_addr_r[7:2], 2'b00};
    wire [7:0]  ra       = {araddr[7:2], 2'b00};
    wire        wr_route = wa == ROUTE_OFF;
    wire        wr_gen   = wa == GEN_OFF;
    wire        wr_iclr  = wa == ICLR_OFF;
    wire        wr_ien   = wa == IEN_OFF;
    wire        wr_hit   = wr_route || wr_gen || wr_iclr || wr_ien;
    wire        rd_route = ra == ROUTE_OFF;
    wire        rd_gen   = ra == GEN_OFF;
    wire        rd_istat = ra == ISTAT_OFF;
    wire        rd_ien   = ra == IEN_OFF;
    wire        rd_hit   = rd_route || rd_gen || rd_istat || rd_ien;

    wire [31:0] wmask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_mask
            assign wmask[8*gi +: 8] = {8{w_strb_r[gi]}};
        end
    endgenerate

    // Stored fields only; reserved positions stay zero
    wire [31:0] route_q = {route_r, 7'h00, pin_en_r};          // [RL17]
    wire [31:0] gen_q   = {7'h00, drop_r, 6'h00, wid_r, spp_r,
                           6'h00, cal_r, en_r};                 // [RL17]
    wire [31:0] ien_q   = {30'h0, ien_r};
    wire [31:0] route_w = (route_q & ~wmask) | (w_data_r & wmask);
    wire [31:0] gen_w   = (gen_q & ~wmask) | (w_data_r & wmask);
    wire [31:0] ien_w   = (ien_q & ~wmask) | (w_data_r & wmask);
    wire [1:0]  iclr_w  = w_data_r[1:0] & {2{w_strb_r[0]}};

    wire [31:0] rd_val  = rd_route ? route_q :
                          rd_gen   ? gen_q :
                          rd_istat ? {30'h0, istat_r} :
                          rd_ien   ? ien_q : 32'h00000000;

    // Pin register is frozen while the converter runs
    wire        route_we = wr_fire && wr_route && !en_r;        // [RL12]
    wire        gen_we   = wr_fire && wr_gen;

    // Sample path
    wire        cal_done = cal_cnt_r == CAL_PULSES;
    wire        take     = sample_pulse && en_r && pin_en_r
                           && cal_done;                 // [RL2] [RL14]
    wire        reg_acc  = (wr_fire && (wr_route || wr_gen))
                           || (ar_fire && (rd_route || rd_gen));
    wire        acc_term = reg_acc && spp_r == 8'h00
                           && pkt_open_r;                       // [RL9]
    // One sample in flight, unaccepted last byte and pending end included
    wire        busy     = bytes_left_r != 3'h0 || end_pend_r
                           || (tx_valid_r && !tx_ready) || acc_term;
    wire        load     = take && !busy;                       // [RL16]
    wire        drop_ev  = take && busy;                        // [RL18]
    wire        spp_hit  = spp_r != 8'h00
                           && pkt_cnt_r + 8'h01 == spp_r;       // [RL8]
    wire [31:0] s8       = {conv_data[11:4], 24'h000000};       // [RL4]
    wire [31:0] s16      = {conv_data, 4'h0, 16'h0000};         // [RL6]
    wire [31:0] s32      = {conv_data, 20'h00000};              // [RL7]
    wire [31:0] s_word   = wid_r == WID_8  ? s8 :
                           wid_r == WID_32 ? s32 : s16;         // [RL5]
    wire [2:0]  s_bytes  = wid_r == WID_8  ? 3'h1 :
                           wid_r == WID_32 ? 3'h4 : 3'h2;
    wire        tx_free  = !tx_valid_r || tx_ready;
    wire        send_b   = tx_free && bytes_left_r != 3'h0;
    wire        send_e   = tx_free && bytes_left_r == 3'h0 && end_pend_r;
    wire [1:0]  ev       = {send_e, drop_ev};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            if (awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (wr_fire) begin
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_val;
            rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_r  <= ROUTE_RST;
            pin_en_r <= 1'b0;
            en_r     <= 1'b0;
            cal_r    <= 1'b0;
            spp_r    <= SPP_RST;
            wid_r    <= WID_RST;
            ien_r    <= 2'h0;
        end else begin
            if (route_we) begin
                route_r  <= route_w[31:ROUTE_LSB];              // [RL1]
                pin_en_r <= route_w[PIN_EN_BIT];                // [RL2]
            end
            if (gen_we) begin
                en_r  <= gen_w[GEN_EN_BIT];
                cal_r <= gen_w[CAL_BIT];                        // [RL10]
                spp_r <= gen_w[SPP_LSB +: 8];
                wid_r <= gen_w[WID_LSB +: 2];
            end
            if (wr_fire && wr_ien) begin
                ien_r <= ien_w[1:0];
            end
        end
    end

    // Event set beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drop_r  <= DROP_RST;
            istat_r <= 2'h0;
            irq_r   <= 1'b0;
        end else begin
            if (drop_ev) begin
                drop_r <= 1'b1;                                 // [RL18]
            end else if (ar_fire && rd_gen) begin
                drop_r <= 1'b0;                                 // [RL3]
            end
            istat_r <= (istat_r & ~(wr_fire && wr_iclr ? iclr_w : 2'h0))
                       | ev;
            irq_r   <= |(istat_r & ien_r);
        end
    end

    // Calibration pulses restart whenever the converter is off
    always_ff @(posedge aclk) begin
        if (!aresetn || !en_r) begin
            cal_cnt_r <= 3'h0;
        end else if (sample_pulse && !cal_done) begin
            cal_cnt_r <= cal_cnt_r + 3'h1;                      // [RL14]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_r         <= 32'h00000000;
            bytes_left_r <= 3'h0;
        end else if (load) begin
            sh_r         <= s_word;
            bytes_left_r <= s_bytes;
        end else if (send_b) begin
            sh_r         <= {sh_r[23:0], 8'h00};                // [RL6]
            bytes_left_r <= bytes_left_r - 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pkt_cnt_r  <= 8'h00;
            pkt_open_r <= 1'b0;
            end_pend_r <= 1'b0;
        end else begin
            if (acc_term || (load && spp_hit)) begin
                pkt_cnt_r  <= 8'h00;
                pkt_open_r <= 1'b0;
            end else if (load) begin
                pkt_cnt_r  <= pkt_cnt_r + 8'h01;
                pkt_open_r <= 1'b1;
            end
            if (acc_term || (load && spp_hit)) begin
                end_pend_r <= 1'b1;                     // [RL8] [RL9]
            end else if (send_e) begin
                end_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_valid_r <= 1'b0;
            tx_end_r   <= 1'b0;
            tx_data_r  <= 8'h00;
        end else if (send_b) begin
            tx_valid_r <= 1'b1;
            tx_end_r   <= 1'b0;
            tx_data_r  <= sh_r[31:24];                          // [RL7]
        end else if (send_e) begin
            tx_valid_r <= 1'b1;
            tx_end_r   <= 1'b1;
            tx_data_r  <= 8'h00;
        end else if (tx_free) begin
            tx_valid_r <= 1'b0;
            tx_end_r   <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    route_lock_a: assert property (                               // [RL12]
        wr_fire && wr_route && en_r |=> $stable(route_r)
    ) else $error("pin register changed while converter enabled");
    drop_clear_a: assert property (                               // [RL3]
        ar_fire && rd_gen && !drop_ev |=> !drop_r
    ) else $error("dropped flag not cleared by read");
    cal_quiet_a: assert property (                                // [RL14]
        cal_cnt_r < CAL_PULSES |-> !load
    ) else $error("sample sent during calibration pulses");
    narrow_len_a: assert property (                               // [RL4]
        load && wid_r == WID_8 |=> bytes_left_r == 3'h1
            && sh_r[31:24] == $past(conv_data[11:4])
    ) else $error("8-bit sample wrong");
    half_order_a: assert property (                               // [RL6]
        load && wid_r == 2'h1 && tx_ready |=> ##1
            tx_valid_r && tx_data_r == $past(conv_data[11:4], 2) ##1
            (!$past(tx_ready)
             || tx_data_r == {$past(conv_data[3:0], 3), 4'h0})
    ) else $error("16-bit sample bytes out of order");
    word_len_a: assert property (                                 // [RL7]
        load && wid_r == WID_32 |=> bytes_left_r == 3'h4
            && sh_r[19:0] == 20'h00000
    ) else $error("32-bit sample wrong");
    left_align_a: assert property (                               // [RL5]
        load |=> sh_r[31:20] == $past(conv_data) || wid_r == WID_8
    ) else $error("sample not left aligned");
    count_end_a: assert property (                                // [RL8]
        load && spp_hit |=> end_pend_r && pkt_cnt_r == 8'h00
    ) else $error("packet not ended at sample count");
    open_end_a: assert property (                                 // [RL9]
        acc_term |=> end_pend_r && !pkt_open_r
    ) else $error("open packet not ended on access");
    drop_set_a: assert property (                                 // [RL18]
        drop_ev |=> drop_r && istat_r[IRQ_DROP]
    ) else $error("drop not flagged");
    cal_write_a: assert property (                                // [RL10]
        gen_we && w_strb_r[0] |=> cal_sel == $past(w_data_r[CAL_BIT])
    ) else $error("calibration select not updated");
endmodule

// *** dv/channel_end_rx.sv ***
`timescale 1ns/1ps
module channel_end_rx (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_end,
    output logic            tx_ready
);
    // Items as {end, byte}; the bench pops them in order
    logic [8:0] q[$];

    // Ready lags stall by one edge, as a filling channel end would
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_ready <= 1'b0;
            q.delete();
        end else begin
            tx_ready <= !stall;
            if (tx_valid && tx_ready) begin
                q.push_back({tx_end, tx_data});
            end
        end
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    import adc_pkt_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, sample_pulse = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        cal_sel, tx_valid, tx_ready, tx_end;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_data;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, rs, bs;
    logic [11:0] conv_data = 12'h000;
    logic [23:0] tx_dest;
    int          errors = 0;
    int          total_checks = 0;
    logic [1:0]  wlist [2] = '{2'h0, 2'h3};

    always #20 aclk = ~aclk;

    adc_pkt_ctrl adc_pkt_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .sample_pulse(sample_pulse), .conv_data(conv_data),
        .cal_sel(cal_sel), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .tx_end(tx_end), .tx_dest(tx_dest), .irq(irq));
    channel_end_rx channel_end_rx_inst (.aclk(aclk), .aresetn(aresetn),
        .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_end(tx_end), .tx_ready(tx_ready));

    task automatic end_of_test;
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rx_exp(input logic [8:0] e);
        logic [8:0] got;
        got = 9'h1FF;
        if (channel_end_rx_inst.q.size() > 0)
            got = channel_end_rx_inst.q.pop_front();
        check("rx item", {23'h0, got}, {23'h0, e});
    endtask

    // Sample right after a mode switch is not trusted
    task automatic rx_skip;
        logic [8:0] junk;
        if (channel_end_rx_inst.q.size() > 0)
            junk = channel_end_rx_inst.q.pop_front();
    endtask

    task automatic rx_none;
        check("rx count", 32'(channel_end_rx_inst.q.size()), 32'h0);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        while (!bvalid) @(posedge aclk);
        bs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic pulse(input logic [11:0] v, input int n);
        sample_pulse <= 1'b1;
        conv_data <= v;
        @(posedge aclk);
        sample_pulse <= 1'b0;
        repeat (n) @(posedge aclk);
    endtask

    // Disable, set up, enable, then burn the calibration pulses
    task automatic start(input logic [31:0] g);
        axi_wr(GEN_OFF, g);
        axi_wr(GEN_OFF, g | 32'h1);
        repeat (6) pulse(12'hABC, 10);
        rx_none();
    endtask

    task automatic t_reset;
        axi_rd(ROUTE_OFF);
        check("route reset", rd, 32'h0);
        axi_rd(GEN_OFF);
        check("gen reset", rd, 32'h0101_0100);
        axi_rd(GEN_OFF);
        check("drop cleared", rd, 32'h0001_0100);
        axi_rd(8'h40);
        check("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        axi_wr(8'h40, 32'hFFFF_FFFF);
        check("unmapped wr resp", {30'h0, bs}, {30'h0, RESP_SLVERR});
    endtask

    task automatic t_regs;
        axi_wr(ROUTE_OFF, 32'hFFFF_FFFF);
        axi_rd(ROUTE_OFF);
        check("route", rd, 32'hFFFF_FF01);
        check("route wr resp", {30'h0, bs}, {30'h0, RESP_OKAY});
        wstrb <= 4'hE;
        axi_wr(ROUTE_OFF, 32'h1234_5600);
        wstrb <= 4'hF;
        axi_rd(ROUTE_OFF);
        check("route strobe", rd, 32'h1234_5601);
        axi_wr(GEN_OFF, 32'hFFFC_00FE);
        axi_rd(GEN_OFF);
        check("gen reserved", rd, 32'h0000_0002);
        check("cal_sel", {31'h0, cal_sel}, 32'h1);
    endtask

    task automatic t_stream;
        start(32'h0001_0100);
        pulse(12'h5A7, 10);
        rx_exp(9'h05A);
        rx_exp(9'h070);
        rx_exp(9'h100);
        check("dest", {8'h0, tx_dest}, 32'h0012_3456);
        axi_wr(ROUTE_OFF, 32'h0);
        check("locked resp", {30'h0, bs}, {30'h0, RESP_OKAY});
        axi_rd(ROUTE_OFF);
        check("route locked", rd, 32'h1234_5601);
        foreach (wlist[i]) begin
            start({14'h0, wlist[i], 16'h0100});
            pulse(12'hC35, 12);
            rx_exp(9'h0C3);
            if (wlist[i] == 2'h3) begin
                rx_exp(9'h050);
                rx_exp(9'h000);
                rx_exp(9'h000);
            end
            rx_exp(9'h100);
        end
    endtask

    task automatic t_packet;
        start(32'h0000_0200);
        pulse(12'h123, 10);
        pulse(12'h456, 10);
        rx_exp(9'h012);
        rx_exp(9'h045);
        rx_exp(9'h100);
        axi_wr(GEN_OFF, 32'h0000_0001);
        pulse(12'h789, 10);
        rx_exp(9'h078);
        rx_none();
        axi_rd(GEN_OFF);
        repeat (6) @(posedge aclk);
        rx_exp(9'h100);
        axi_wr(GEN_OFF, 32'h0000_0103);
        check("cal enter", {31'h0, cal_sel}, 32'h1);
        pulse(12'h0AA, 10);
        rx_skip();
        rx_skip();
        pulse(12'h333, 10);
        rx_exp(9'h033);
        rx_exp(9'h100);
        axi_wr(GEN_OFF, 32'h0000_0001);
        check("cal exit", {31'h0, cal_sel}, 32'h0);
        pulse(12'h0BB, 10);
        rx_skip();
        rx_none();
    endtask

    task automatic t_drop;
        axi_wr(ICLR_OFF, 32'h3);
        axi_wr(IEN_OFF, 32'h1);
        stall <= 1'b1;
        repeat (2) @(posedge aclk);
        pulse(12'h111, 2);
        pulse(12'h222, 4);
        axi_rd(ISTAT_OFF);
        check("irq status", rd, 32'h1);
        check("irq raised", {31'h0, irq}, 32'h1);
        axi_rd(GEN_OFF);
        check("drop flag", rd, 32'h0100_0001);
        axi_wr(ICLR_OFF, 32'h1);
        repeat (2) @(posedge aclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        stall <= 1'b0;
        repeat (10) @(posedge aclk);
        rx_exp(9'h011);
        rx_exp(9'h100);
        rx_none();
        check("irq masked", {31'h0, irq}, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_regs();
        t_stream();
        t_packet();
        t_drop();
        end_of_test();
    end

    // Whole run is under two thousand cycles; this is ample margin
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        end_of_test();
    end
endmodule
